// File: include/urb_pkg.sv
// How it works
// (RULE1) The bit rate is one sixteenth of the system clock divided by a divisor from the rate code.
// (RULE2) The divisor never drops below one, so no rate is faster than the clock over sixteen.
// (RULE3) Rate codes 1 to 15 pick fixed rates from 110 to 1,250,000 baud, with 9 (19,200) as default.
// (RULE4) Transmit and receive engines are independent and run at the same time at any rate.
// (RULE5) After reset the frame is eight data bits, one stop bit and no parity.
// (RULE6) Data bit count, stop bit count and parity stay writable in the control register.
// (RULE7) Each received byte is stored into the receive ring by the receive DMA channel, no interrupt.
// (RULE8) Reception fills the ring circularly and never stalls; new bytes overwrite old ones silently.
// (RULE9) Reception runs until reset or until software closes the port.
// (RULE10) The unread count is write pointer minus read pointer around the ring; zero means empty.
// (RULE11) Each read of a received byte advances the read pointer by one, oldest byte first.
// (RULE12) When the transmit head equals the tail the transmit interrupt enable drops, else a byte goes out.
// (RULE13) Once every queued byte has left, the transmit busy flag clears.
// (RULE14) The remote sender needs no request-to-send pause; the port offers no flow control.
// (RULE15) Transmit and receive each have their own rate code.
// (RULE16) The receive write pointer wraps to the ring base when it reaches the programmed size.
package urb_pkg;
    localparam int URB_CLK_PERIOD_NS = 10;
    localparam int URB_CLK_HZ = 1_000_000_000 / URB_CLK_PERIOD_NS;
    localparam int URB_OVERSAMPLE = 16;
    localparam int URB_DIV_W = 20;
    localparam int URB_RX_DEPTH = 256;
    localparam int URB_TX_DEPTH = 16;
    localparam int URB_DW = 16;

    localparam logic [3:0] URB_RATE_DEFAULT = 4'h9;
    localparam logic [7:0] URB_RATE_RESET = 8'h99;

    localparam logic [3:0] URB_A_CTRL = 4'h0;
    localparam logic [3:0] URB_A_RATE = 4'h1;
    localparam logic [3:0] URB_A_RX_SIZE = 4'h2;
    localparam logic [3:0] URB_A_RX_DATA = 4'h3;
    localparam logic [3:0] URB_A_RX_COUNT = 4'h4;
    localparam logic [3:0] URB_A_TX_DATA = 4'h5;
    localparam logic [3:0] URB_A_TX_STAT = 4'h6;
    localparam logic [3:0] URB_A_IRQ_STAT = 4'h7;
    localparam logic [3:0] URB_A_IRQ_MASK = 4'h8;

    localparam int URB_CTRL_W = 5;
    localparam int URB_C_OPEN = 0;
    localparam int URB_C_DATA7 = 1;
    localparam int URB_C_STOP2 = 2;
    localparam int URB_C_PAR_EN = 3;
    localparam int URB_C_PAR_ODD = 4;
    localparam logic [URB_CTRL_W-1:0] URB_CTRL_RESET = 5'h00;

    localparam int URB_IRQ_W = 2;
    localparam int URB_S_TX_DONE = 0;
    localparam int URB_S_RX_FERR = 1;

    localparam logic [3:0] URB_OS_MID = 4'h7;
    localparam logic [3:0] URB_OS_LAST = 4'hf;
    localparam logic [2:0] URB_BITS8_LAST = 3'h7;
    localparam logic [2:0] URB_BITS7_LAST = 3'h6;

    typedef enum logic [2:0] {URB_IDLE, URB_START, URB_DATA, URB_PAR, URB_STOP} urb_state_t;

    // Code 0 is not a valid selection and falls back to the default rate
    function automatic int urb_baud_f(input logic [3:0] code);
        case (code)
            4'h1: return 110;
            4'h2: return 150;
            4'h3: return 300;
            4'h4: return 600;
            4'h5: return 1200;
            4'h6: return 2400;
            4'h7: return 4800;
            4'h8: return 9600;
            4'ha: return 38400;
            4'hb: return 57600;
            4'hc: return 115200;
            4'hd: return 250000;
            4'he: return 500000;
            4'hf: return 1250000;
            default: return 19200;
        endcase
    endfunction
endpackage

// File: include/urb_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface urb_tick_if;
    logic [3:0] rate_code;
    logic tick;
    modport gen (input rate_code, output tick);
    modport user (output rate_code, input tick);
endinterface
`default_nettype wire

// File: rtl/urb_baud_gen.sv
`timescale 1ns/100ps
`default_nettype none
module urb_baud_gen
    import urb_pkg::*;
(
    input wire logic clk_sys_i, // System clock
    input wire logic rst_b_i, // Synchronous reset, active low
    urb_tick_if.gen tk // Rate code in, oversample tick out
);
    logic [URB_DIV_W-1:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt;
    logic [URB_DIV_W-1:0] div_w;
    int div_i;

    always_comb begin
        div_i = URB_CLK_HZ / (URB_OVERSAMPLE * urb_baud_f(tk.rate_code)); // [RULE1] [RULE3]
        if (div_i < 1) begin
            div_i = 1; // [RULE2]
        end
        div_w = URB_DIV_W'(div_i);
    end

    always_comb begin
        cnt_nxt = cnt_r - 1'b1;
        tick_nxt = 1'b0;
        // A shrunken divisor after a rate change reloads at once rather than running out
        if (cnt_r == '0 || cnt_r >= div_w) begin
            cnt_nxt = div_w - 1'b1;
            tick_nxt = (cnt_r == '0);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r;

    a_div_floor: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [RULE2]
        div_w >= URB_DIV_W'(1)) else $error("divisor below one");
    a_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [RULE1]
        tick_r && div_w > URB_DIV_W'(1) && $stable(tk.rate_code) |=> !tick_r)
        else $error("ticks closer than divisor allows");
endmodule
`default_nettype wire

// File: rtl/urb_uart_ring.sv
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module urb_uart_ring
    import urb_pkg::*;
#(
    parameter int RX_DEPTH = URB_RX_DEPTH,
    parameter int TX_DEPTH = URB_TX_DEPTH
) (
    input wire logic clk_sys_i, // System clock, 100 MHz
    input wire logic rst_b_i, // Synchronous reset, active low
    input wire logic [3:0] addr_i, // Register address
    input wire logic [URB_DW-1:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [URB_DW-1:0] rdata_o, // Read data, cycle after strobe
    input wire logic rxd_i, // Serial receive line
    output logic txd_o, // Serial transmit line
    output logic irq_o // Level interrupt
);
    localparam int RAW = $clog2(RX_DEPTH);
    localparam int TAW = $clog2(TX_DEPTH);

    urb_tick_if tx_tk();
    urb_tick_if rx_tk();

    logic [URB_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [7:0] rate_r, rate_nxt;
    logic [RAW:0] rx_size_r, rx_size_nxt;
    logic [URB_IRQ_W-1:0] status_r, status_nxt, mask_r, mask_nxt;
    logic [URB_DW-1:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic [RAW-1:0] rx_rptr_r, rx_rptr_nxt;
    logic [TAW-1:0] tx_head_r, tx_head_nxt;

    logic [7:0] rx_mem [RX_DEPTH];
    logic [7:0] tx_mem [TX_DEPTH];

    urb_state_t rx_state_r, rx_state_nxt;
    logic [3:0] rx_os_r, rx_os_nxt;
    logic [2:0] rx_bit_r, rx_bit_nxt;
    logic [7:0] rx_shift_r, rx_shift_nxt;
    logic rx_par_r, rx_par_nxt;
    logic [RAW-1:0] rx_wptr_r, rx_wptr_nxt;
    logic rx_wr_en, rx_ferr_ev;
    logic [7:0] rx_byte;

    urb_state_t tx_state_r, tx_state_nxt;
    logic [3:0] tx_os_r, tx_os_nxt;
    logic [2:0] tx_bit_r, tx_bit_nxt;
    logic [7:0] tx_shift_r, tx_shift_nxt;
    logic tx_par_r, tx_par_nxt;
    logic [TAW-1:0] tx_tail_r, tx_tail_nxt;
    logic tx_ie_r, tx_ie_nxt, tx_busy_r, tx_busy_nxt, txd_r, txd_nxt;
    logic tx_done_ev;

    logic [RAW:0] rx_count;
    logic tx_full, tx_push, rx_pop;
    logic [2:0] last_bit;

    assign tx_tk.rate_code = rate_r[3:0]; // [RULE15]
    assign rx_tk.rate_code = rate_r[7:4]; // [RULE15]

    urb_baud_gen u_tx_baud (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .tk(tx_tk.gen)
    );
    urb_baud_gen u_rx_baud (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .tk(rx_tk.gen)
    );

    assign last_bit = ctrl_r[URB_C_DATA7] ? URB_BITS7_LAST : URB_BITS8_LAST; // [RULE6]
    assign rx_count = ({1'b0, rx_wptr_r} >= {1'b0, rx_rptr_r}) ? // [RULE10]
        {1'b0, rx_wptr_r} - {1'b0, rx_rptr_r} :
        {1'b0, rx_wptr_r} + rx_size_r - {1'b0, rx_rptr_r};
    assign tx_full = (TAW'(tx_head_r + 1'b1) == tx_tail_r);
    assign tx_push = wr_i && addr_i == URB_A_TX_DATA && !tx_full;
    assign rx_pop = rd_i && addr_i == URB_A_RX_DATA && rx_count != '0;

    // Register port
    always_comb begin
        ctrl_nxt = ctrl_r;
        rate_nxt = rate_r;
        rx_size_nxt = rx_size_r;
        mask_nxt = mask_r;
        rx_rptr_nxt = rx_rptr_r;
        tx_head_nxt = tx_head_r;
        rdata_nxt = '0;
        status_nxt = status_r;
        if (wr_i) begin
            if (addr_i == URB_A_CTRL) begin
                ctrl_nxt = wdata_i[URB_CTRL_W-1:0]; // [RULE6]
            end else if (addr_i == URB_A_RATE) begin
                rate_nxt = wdata_i[7:0];
            end else if (addr_i == URB_A_RX_SIZE) begin
                // Sizes outside 1..depth would leave the ring unbounded
                if (wdata_i != '0 && wdata_i <= URB_DW'(RX_DEPTH)) begin
                    rx_size_nxt = wdata_i[RAW:0];
                end
            end else if (addr_i == URB_A_IRQ_STAT) begin
                status_nxt = status_r & ~wdata_i[URB_IRQ_W-1:0];
            end else if (addr_i == URB_A_IRQ_MASK) begin
                mask_nxt = wdata_i[URB_IRQ_W-1:0];
            end
        end
        if (tx_push) begin
            tx_head_nxt = TAW'(tx_head_r + 1'b1);
        end
        if (rx_pop) begin
            rx_rptr_nxt = (RAW'(rx_rptr_r + 1'b1) == RAW'(rx_size_r) || // [RULE11]
                {1'b0, rx_rptr_r} + 1'b1 >= rx_size_r) ? '0 : RAW'(rx_rptr_r + 1'b1);
        end
        if (rd_i) begin
            if (addr_i == URB_A_CTRL) begin
                rdata_nxt = URB_DW'(ctrl_r);
            end else if (addr_i == URB_A_RATE) begin
                rdata_nxt = URB_DW'(rate_r);
            end else if (addr_i == URB_A_RX_SIZE) begin
                rdata_nxt = URB_DW'(rx_size_r);
            end else if (addr_i == URB_A_RX_DATA) begin
                rdata_nxt = URB_DW'(rx_mem[rx_rptr_r]);
            end else if (addr_i == URB_A_RX_COUNT) begin
                rdata_nxt = URB_DW'(rx_count); // [RULE10]
            end else if (addr_i == URB_A_TX_STAT) begin
                rdata_nxt = URB_DW'({tx_full, tx_ie_r, tx_busy_r});
            end else if (addr_i == URB_A_IRQ_STAT) begin
                rdata_nxt = URB_DW'(status_r);
            end else if (addr_i == URB_A_IRQ_MASK) begin
                rdata_nxt = URB_DW'(mask_r);
            end
        end
        // A new event wins over a clear in the same cycle
        status_nxt[URB_S_TX_DONE] = status_nxt[URB_S_TX_DONE] | tx_done_ev;
        status_nxt[URB_S_RX_FERR] = status_nxt[URB_S_RX_FERR] | rx_ferr_ev;
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ctrl_r <= URB_CTRL_RESET; // [RULE5]
            rate_r <= URB_RATE_RESET; // [RULE3]
            rx_size_r <= (RAW+1)'(RX_DEPTH);
            mask_r <= '0;
            status_r <= '0;
            rdata_r <= '0;
            irq_r <= 1'b0;
            rx_rptr_r <= '0;
            tx_head_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            rate_r <= rate_nxt;
            rx_size_r <= rx_size_nxt;
            mask_r <= mask_nxt;
            status_r <= status_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            rx_rptr_r <= rx_rptr_nxt;
            tx_head_r <= tx_head_nxt;
        end
    end

    // Receive engine, oversampled; no request-to-send output exists to pause the sender [RULE14]
    always_comb begin
        rx_state_nxt = rx_state_r;
        rx_os_nxt = rx_os_r;
        rx_bit_nxt = rx_bit_r;
        rx_shift_nxt = rx_shift_r;
        rx_par_nxt = rx_par_r;
        rx_wptr_nxt = rx_wptr_r;
        rx_wr_en = 1'b0;
        rx_ferr_ev = 1'b0;
        rx_byte = ctrl_r[URB_C_DATA7] ? {1'b0, rx_shift_r[7:1]} : rx_shift_r;
        case (rx_state_r)
            URB_IDLE: begin
                if (!rxd_i) begin
                    rx_state_nxt = URB_START;
                    rx_os_nxt = '0;
                end
            end
            URB_START: begin
                if (rx_tk.tick) begin
                    rx_os_nxt = rx_os_r + 1'b1;
                    if (rx_os_r == URB_OS_MID) begin
                        rx_state_nxt = rxd_i ? URB_IDLE : URB_DATA;
                        rx_os_nxt = '0;
                        rx_bit_nxt = '0;
                        rx_par_nxt = ctrl_r[URB_C_PAR_ODD];
                    end
                end
            end
            URB_DATA: begin
                if (rx_tk.tick) begin
                    rx_os_nxt = rx_os_r + 1'b1;
                    if (rx_os_r == URB_OS_LAST) begin
                        rx_shift_nxt = {rxd_i, rx_shift_r[7:1]};
                        rx_par_nxt = rx_par_r ^ rxd_i;
                        rx_bit_nxt = rx_bit_r + 1'b1;
                        if (rx_bit_r == last_bit) begin
                            rx_state_nxt = ctrl_r[URB_C_PAR_EN] ? URB_PAR : URB_STOP;
                        end
                    end
                end
            end
            URB_PAR: begin
                if (rx_tk.tick) begin
                    rx_os_nxt = rx_os_r + 1'b1;
                    if (rx_os_r == URB_OS_LAST) begin
                        rx_par_nxt = rx_par_r ^ rxd_i;
                        rx_state_nxt = URB_STOP;
                    end
                end
            end
            URB_STOP: begin
                if (rx_tk.tick) begin
                    rx_os_nxt = rx_os_r + 1'b1;
                    if (rx_os_r == URB_OS_LAST) begin
                        rx_state_nxt = URB_IDLE;
                        if (rxd_i && !(ctrl_r[URB_C_PAR_EN] && rx_par_r)) begin
                            // Stored without regard to unread data [RULE7] [RULE8]
                            rx_wr_en = 1'b1;
                            rx_wptr_nxt = ({1'b0, rx_wptr_r} + 1'b1 >= rx_size_r) ? // [RULE16]
                                '0 : RAW'(rx_wptr_r + 1'b1);
                        end else begin
                            rx_ferr_ev = 1'b1;
                        end
                    end
                end
            end
            default: rx_state_nxt = URB_IDLE;
        endcase
        if (!ctrl_r[URB_C_OPEN]) begin
            rx_state_nxt = URB_IDLE; // [RULE9]
            rx_wr_en = 1'b0;
            rx_ferr_ev = 1'b0;
            rx_wptr_nxt = rx_wptr_r;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rx_state_r <= URB_IDLE;
            rx_os_r <= '0;
            rx_bit_r <= '0;
            rx_shift_r <= '0;
            rx_par_r <= 1'b0;
            rx_wptr_r <= '0;
        end else begin
            rx_state_r <= rx_state_nxt;
            rx_os_r <= rx_os_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_shift_r <= rx_shift_nxt;
            rx_par_r <= rx_par_nxt;
            rx_wptr_r <= rx_wptr_nxt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rx_wr_en) begin
            rx_mem[rx_wptr_r] <= rx_byte; // [RULE7]
        end
        if (tx_push) begin
            tx_mem[tx_head_r] <= wdata_i[7:0];
        end
    end

    // Transmit engine, runs alongside the receiver [RULE4]
    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_os_nxt = tx_os_r;
        tx_bit_nxt = tx_bit_r;
        tx_shift_nxt = tx_shift_r;
        tx_par_nxt = tx_par_r;
        tx_tail_nxt = tx_tail_r;
        tx_ie_nxt = tx_ie_r;
        tx_busy_nxt = tx_busy_r;
        txd_nxt = 1'b1;
        tx_done_ev = 1'b0;
        case (tx_state_r)
            URB_IDLE: begin
                if (tx_ie_r && ctrl_r[URB_C_OPEN]) begin
                    if (tx_head_r == tx_tail_r) begin
                        tx_ie_nxt = 1'b0; // [RULE12]
                        tx_busy_nxt = 1'b0; // [RULE13]
                        tx_done_ev = 1'b1;
                    end else begin
                        tx_shift_nxt = tx_mem[tx_tail_r]; // [RULE12]
                        tx_tail_nxt = TAW'(tx_tail_r + 1'b1);
                        tx_state_nxt = URB_START;
                        tx_os_nxt = '0;
                        tx_bit_nxt = '0;
                        tx_par_nxt = ctrl_r[URB_C_PAR_ODD];
                    end
                end
            end
            URB_START: begin
                txd_nxt = 1'b0;
                if (tx_tk.tick) begin
                    tx_os_nxt = tx_os_r + 1'b1;
                    if (tx_os_r == URB_OS_LAST) begin
                        tx_state_nxt = URB_DATA;
                    end
                end
            end
            URB_DATA: begin
                txd_nxt = tx_shift_r[0];
                if (tx_tk.tick) begin
                    tx_os_nxt = tx_os_r + 1'b1;
                    if (tx_os_r == URB_OS_LAST) begin
                        tx_shift_nxt = {1'b0, tx_shift_r[7:1]};
                        tx_par_nxt = tx_par_r ^ tx_shift_r[0];
                        tx_bit_nxt = tx_bit_r + 1'b1;
                        if (tx_bit_r == last_bit) begin
                            tx_state_nxt = ctrl_r[URB_C_PAR_EN] ? URB_PAR : URB_STOP;
                            tx_bit_nxt = '0;
                        end
                    end
                end
            end
            URB_PAR: begin
                txd_nxt = tx_par_r;
                if (tx_tk.tick) begin
                    tx_os_nxt = tx_os_r + 1'b1;
                    if (tx_os_r == URB_OS_LAST) begin
                        tx_state_nxt = URB_STOP;
                    end
                end
            end
            URB_STOP: begin
                if (tx_tk.tick) begin
                    tx_os_nxt = tx_os_r + 1'b1;
                    if (tx_os_r == URB_OS_LAST) begin
                        tx_bit_nxt = tx_bit_r + 1'b1;
                        if (tx_bit_r[0] || !ctrl_r[URB_C_STOP2]) begin // [RULE6]
                            tx_state_nxt = URB_IDLE;
                        end
                    end
                end
            end
            default: tx_state_nxt = URB_IDLE;
        endcase
        if (tx_push) begin
            tx_ie_nxt = 1'b1;
            tx_busy_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            tx_state_r <= URB_IDLE;
            tx_os_r <= '0;
            tx_bit_r <= '0;
            tx_shift_r <= '0;
            tx_par_r <= 1'b0;
            tx_tail_r <= '0;
            tx_ie_r <= 1'b0;
            tx_busy_r <= 1'b0;
            txd_r <= 1'b1;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_os_r <= tx_os_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_shift_r <= tx_shift_nxt;
            tx_par_r <= tx_par_nxt;
            tx_tail_r <= tx_tail_nxt;
            tx_ie_r <= tx_ie_nxt;
            tx_busy_r <= tx_busy_nxt;
            txd_r <= txd_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign txd_o = txd_r;
    assign irq_o = irq_r;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    a_rx_ring_wrap: assert property ( // [RULE16]
        rx_wr_en && {1'b0, rx_wptr_r} + 1'b1 == rx_size_r |=> rx_wptr_r == '0)
        else $error("receive pointer did not wrap at ring size");
    a_rx_no_stall: assert property ( // [RULE8]
        rx_wr_en && rx_size_r > 1 |=> rx_wptr_r != $past(rx_wptr_r))
        else $error("receive pointer stalled on a stored byte");
    a_rx_pop_step: assert property ( // [RULE11]
        rx_pop && rx_size_r > 1 |=> rx_rptr_r != $past(rx_rptr_r) && rdata_r[7:0] == $past(rx_mem[rx_rptr_r]))
        else $error("read did not return oldest byte and advance");
    a_rx_count_empty: assert property ( // [RULE10]
        rx_count == '0 |-> rx_wptr_r == rx_rptr_r)
        else $error("zero count with unequal pointers");
    a_rx_closed_idle: assert property ( // [RULE9]
        !ctrl_r[URB_C_OPEN] |=> rx_state_r == URB_IDLE && rx_wptr_r == $past(rx_wptr_r))
        else $error("receiver active while closed");
    a_tx_ie_drop: assert property ( // [RULE12]
        tx_state_r == URB_IDLE && tx_ie_r && ctrl_r[URB_C_OPEN] && tx_head_r == tx_tail_r && !tx_push
        |=> !tx_ie_r ##0 !tx_busy_r)
        else $error("transmit enable held with empty ring");
    a_tx_busy_hold: assert property ( // [RULE13]
        tx_state_r != URB_IDLE |-> tx_busy_r)
        else $error("busy clear while a byte is on the line");
    a_tx_start_low: assert property ( // [RULE5]
        tx_state_r == URB_START [*2] |-> !txd_r)
        else $error("start bit not driven low");
endmodule
`default_nettype wire

// File: verification/urb_serial_peer.sv
`timescale 1ns/100ps
`default_nettype none
module urb_serial_peer #(
    parameter int BIT_CLK = 80
) (
    input wire logic clk_i, // System clock
    input wire logic txd_i, // Line from the port transmitter
    output logic rxd_o // Line into the port receiver
);
    logic [7:0] got_q[$];
    initial rxd_o = 1'b1;
    // Sends whenever told; it never waits on request-to-send
    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i) rxd_o <= fr[i];
            repeat (BIT_CLK - 1) @(posedge clk_i);
        end
        @(posedge clk_i) rxd_o <= 1'b1;
    endtask
    // Samples mid-bit on the falling edge, clear of the port's own updates
    initial begin : rx_side
        logic [7:0] b;
        forever begin
            @(negedge clk_i);
            if (txd_i === 1'b0) begin
                repeat (BIT_CLK / 2) @(negedge clk_i);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CLK) @(negedge clk_i);
                    b[i] = txd_i;
                end
                repeat (BIT_CLK) @(negedge clk_i);
                if (txd_i === 1'b1) got_q.push_back(b);
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/urb_uart_ring_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module urb_uart_ring_tb_top import urb_pkg::*;;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [URB_DW-1:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [URB_DW-1:0] rdata;
    logic [URB_DW-1:0] v;
    logic txd;
    logic rxd;
    logic irq;
    int error_cnt = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    urb_uart_ring u_urb_uart_ring (.clk_sys_i(clk), .rst_b_i(rst_b), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rxd_i(rxd), .txd_o(txd),
        .irq_o(irq));
    urb_serial_peer u_urb_serial_peer (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
    task automatic wrap_up();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [URB_DW-1:0] got, input logic [URB_DW-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [URB_DW-1:0] d);
        @(posedge clk) begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
        end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk) begin
            addr <= a;
            rd <= 1'b1;
        end
        @(posedge clk) rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [URB_DW-1:0] exp);
        rd_reg(a);
        chk(v, exp);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        chk_rd(URB_A_CTRL, 16'h0000);
        chk_rd(URB_A_RATE, 16'h0099);
        chk_rd(URB_A_RX_SIZE, 16'h0100);
        chk_rd(URB_A_RX_COUNT, 16'h0000);
        chk_rd(4'hf, 16'h0000);
        wr_reg(URB_A_CTRL, 16'h001d);
        chk_rd(URB_A_CTRL, 16'h001d);
        // Fastest code on both sides gives 80 clocks per bit, the peer's setting
        wr_reg(URB_A_RATE, 16'h00ff);
        wr_reg(URB_A_CTRL, 16'h0001);
        wr_reg(URB_A_RX_SIZE, 16'h0004);
        wr_reg(URB_A_IRQ_MASK, 16'h0001);
        fork
            for (int i = 0; i < 3; i++) u_urb_serial_peer.send_byte(8'(8'ha1 + 8'h11 * i), 1'b1);
            begin
                wr_reg(URB_A_TX_DATA, 16'h005a);
                wr_reg(URB_A_TX_DATA, 16'h003c);
                chk_rd(URB_A_TX_STAT, 16'h0003);
            end
        join
        repeat (20) @(posedge clk);
        chk_rd(URB_A_RX_COUNT, 16'h0003);
        chk_rd(URB_A_RX_DATA, 16'h00a1);
        chk_rd(URB_A_RX_DATA, 16'h00b2);
        for (int i = 0; i <= 2000; i++) begin
            rd_reg(URB_A_TX_STAT);
            if (v[0] === 1'b0) break;
            if (i == 2000) begin
                error_cnt++;
            end
        end
        chk(v, 16'h0000);
        chk_rd(URB_A_IRQ_STAT, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        chk(16'(u_urb_serial_peer.got_q.size()), 16'h0002);
        chk({8'h00, u_urb_serial_peer.got_q[0]}, 16'h005a);
        chk({8'h00, u_urb_serial_peer.got_q[1]}, 16'h003c);
        wr_reg(URB_A_IRQ_STAT, 16'h0001);
        chk_rd(URB_A_IRQ_STAT, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        // Seven bytes into a four-slot ring: slots 0..2 are rewritten
        for (int i = 1; i <= 4; i++) u_urb_serial_peer.send_byte(8'(i), 1'b1);
        repeat (20) @(posedge clk);
        chk_rd(URB_A_RX_COUNT, 16'h0001);
        chk_rd(URB_A_RX_DATA, 16'h0004);
        chk_rd(URB_A_RX_COUNT, 16'h0000);
        // Seven data bits, even parity, two stop bits; the peer sees the parity bit as bit 7
        wr_reg(URB_A_CTRL, 16'h000f);
        wr_reg(URB_A_TX_DATA, 16'h0031);
        u_urb_serial_peer.send_byte(8'hb1, 1'b1);
        u_urb_serial_peer.send_byte(8'h31, 1'b1);
        repeat (20) @(posedge clk);
        chk_rd(URB_A_RX_COUNT, 16'h0001);
        chk_rd(URB_A_RX_DATA, 16'h0031);
        chk({8'h00, u_urb_serial_peer.got_q[2]}, 16'h00b1);
        chk_rd(URB_A_IRQ_STAT, 16'h0003);
        wr_reg(URB_A_IRQ_STAT, 16'h0003);
        wr_reg(URB_A_CTRL, 16'h0000);
        u_urb_serial_peer.send_byte(8'h77, 1'b1);
        repeat (20) @(posedge clk);
        chk_rd(URB_A_RX_COUNT, 16'h0000);
        // A full ring refuses the sixteenth byte; the closed port keeps the rest queued
        for (int i = 0; i < 16; i++) wr_reg(URB_A_TX_DATA, 16'(i));
        chk_rd(URB_A_TX_STAT, 16'h0007);
        // Broken stop bit: byte dropped and flagged
        wr_reg(URB_A_CTRL, 16'h0001);
        wr_reg(URB_A_IRQ_MASK, 16'h0002);
        u_urb_serial_peer.send_byte(8'h66, 1'b0);
        chk_rd(URB_A_IRQ_STAT, 16'h0002);
        chk({15'h0000, irq}, 16'h0001);
        wrap_up();
    end
endmodule
`default_nettype wire
